// *** verilog/tbdt_pkg.sv ***
// Purpose: Shared constants and carrier types of the terminal board delay timers.
// Assumes: 125 MHz system clock; jumpers and switches are static pins.
// Notes:   Seconds prescaler is derived from the clock rate below.
package tbdt_pkg;
    localparam int unsigned CLK_HZ        = 125000000;  // System clock rate in Hz
    localparam int unsigned UNIT_S        = 1;          // Length of a seconds unit in s
    localparam int unsigned SEC_CYCLES    = CLK_HZ * UNIT_S; // Clock cycles per second
    localparam int          DLY_W         = 7;          // Switch field width
    localparam int          PRE_W         = 27;         // Prescaler counter width
    localparam logic [6:0]  DLY_DEFAULT   = 7'h01;      // Factory setting, one unit
    localparam logic [6:0]  DLY_ZERO      = 7'h00;      // Cleared count
    localparam int          NCH           = 3;          // Number of delay channels
    localparam int          CH_START      = 0;          // Start hold channel index
    localparam int          CH_AUX        = 1;          // Auxiliary contact channel index
    localparam int          CH_CAP        = 2;          // Capacitor contact channel index

    // Unit selection of one channel; seconds is the factory choice
    typedef enum logic [1:0] {
        TBDT_UNIT_SEC = 2'b01,
        TBDT_UNIT_CYC = 2'b10
    } tbdt_unit_t;

    // Indicator lamps as one group
    typedef struct packed {
        logic start_led;
        logic fault_led;
        logic fuse_led;
        logic cap_on_led;
        logic timed_out_led;
    } tbdt_led_t;

    // Relay outputs as one group
    typedef struct packed {
        logic start_now;
        logic start_delayed;
        logic aux_contact;
        logic cap_contact;
        logic fault_relay;
        logic fuse_relay;
        logic trip_relay;
    } tbdt_relay_t;
endpackage : tbdt_pkg

// *** verilog/tbdt_delay.sv ***
// Purpose: One delay channel counting seconds or line cycles up to 127 units.
// Assumes: Tick pulses are single-cycle enables on sys_clk.
// Notes:   Output falls at once when the trigger goes away.
module tbdt_delay
    import tbdt_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    input  wire logic              trigger,
    input  wire logic              unit_cycles,
    input  wire logic [DLY_W-1:0]  length,
    input  wire logic              sec_tick,
    input  wire logic              cyc_tick,
    output logic                   expired
);
    // Channel state
    typedef struct packed {
        logic [DLY_W-1:0] count;  // Units elapsed
        logic             done;   // Delay has run out
    } tbdt_dly_st_t;

    tbdt_dly_st_t st_q;  // Registered state
    tbdt_dly_st_t st_d;  // Next state
    logic         tick;  // Unit pulse of the chosen base

    // Choose unit base per jumper
    assign tick = unit_cycles ? cyc_tick : sec_tick;

    // Next-state logic
    always_comb begin
        st_d = st_q;
        if (!trigger) begin
            // Trigger gone: clear count and output
            st_d.count = DLY_ZERO;
            st_d.done  = 1'b0;
        end else if (!st_q.done) begin
            if (st_q.count >= length) begin
                st_d.done = 1'b1;  // Sum of switch weights reached
            end else if (tick) begin
                st_d.count = st_q.count + 7'h01;  // One unit per tick
            end
        end
    end

    // State register
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign expired = st_q.done;

    // Output never stands without its trigger one cycle earlier
    dly_clear_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !$past(trigger) |-> !expired)
        else $error("delay output stood after trigger removal");

    // Expiry only after the full count
    dly_count_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $rose(expired) |-> ($past(st_q.count) >= $past(length)))
        else $error("delay expired early");
endmodule : tbdt_delay

// *** verilog/tbdt_top.sv ***
// Purpose: Start, auxiliary and capacitor delay timers with indicator lamps.
// Assumes: All field inputs are asynchronous and are synchronised here.
// Notes:   Jumpers and switch fields are read live; change them only while idle.
module tbdt_top
    import tbdt_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    input  wire logic              start_cmd,
    input  wire logic              bypass_closed,
    input  wire logic              fault_in,
    input  wire logic              fuse_open,
    input  wire logic              reset_key,
    input  wire logic              line_sync,
    input  wire logic              start_delay_cycle_jumper,
    input  wire logic              start_delay_second_jumper,
    input  wire logic              aux_delay_cycle_jumper,
    input  wire logic              aux_delay_second_jumper,
    input  wire logic              capacitor_delay_cycle_jumper,
    input  wire logic              capacitor_delay_second_jumper,
    input  wire logic [DLY_W-1:0]  start_delay_switch_field,
    input  wire logic [DLY_W-1:0]  aux_delay_switch_field,
    input  wire logic [DLY_W-1:0]  capacitor_delay_switch_field,
    output tbdt_pkg::tbdt_relay_t  relay,
    output tbdt_pkg::tbdt_led_t    led
);
    import tbdt_pkg::*;

    localparam int NIN = 5 + 6 + 3 * DLY_W + 1;  // Synchronised input bits

    // Whole top-level state in one record
    typedef struct packed {
        logic [NIN-1:0]   s1;        // First sync stage, read only by s2
        logic [NIN-1:0]   s2;        // Second sync stage
        logic             sync_d1;   // Previous line-sync level for edge find
        logic [PRE_W-1:0] pre;       // Seconds prescaler
        logic             sec_tick;  // One-second enable
        logic             cyc_tick;  // Line-cycle enable
        logic             trip;      // Latched trip
        logic             key_d1;    // Previous reset key level
        tbdt_relay_t      relay;     // Relay outputs
        tbdt_led_t        led;       // Lamp outputs
    } tbdt_st_t;

    tbdt_st_t         st_q;       // Registered state
    tbdt_st_t         st_d;       // Next state
    logic [NIN-1:0]   raw;        // Unsynchronised field inputs
    logic             s_start;    // Synchronised start command
    logic             s_bypass;   // Synchronised bypass closed
    logic             s_fault;    // Synchronised fault
    logic             s_fuse;     // Synchronised fuse or disconnect open
    logic             s_key;      // Synchronised reset key
    logic             s_line;     // Synchronised line sync
    logic [5:0]       s_jmp;      // Synchronised jumpers
    logic [DLY_W-1:0] s_len [NCH];// Synchronised switch fields
    logic [NCH-1:0]   unit_cyc;   // Per channel: cycles selected
    logic [NCH-1:0]   trig;       // Per channel trigger
    logic [NCH-1:0]   expd;       // Per channel expired

    // Gather all pins into one bus for the synchroniser
    assign raw = {line_sync, start_cmd, bypass_closed, fault_in, fuse_open, reset_key,
                  capacitor_delay_second_jumper, capacitor_delay_cycle_jumper,
                  aux_delay_second_jumper, aux_delay_cycle_jumper,
                  start_delay_second_jumper, start_delay_cycle_jumper,
                  capacitor_delay_switch_field, aux_delay_switch_field,
                  start_delay_switch_field};

    // Split the second stage back into named signals
    assign s_len[CH_START] = st_q.s2[DLY_W-1:0];
    assign s_len[CH_AUX]   = st_q.s2[2*DLY_W-1:DLY_W];
    assign s_len[CH_CAP]   = st_q.s2[3*DLY_W-1:2*DLY_W];
    assign s_jmp           = st_q.s2[3*DLY_W+5:3*DLY_W];
    assign s_key           = st_q.s2[3*DLY_W+6];
    assign s_fuse          = st_q.s2[3*DLY_W+7];
    assign s_fault         = st_q.s2[3*DLY_W+8];
    assign s_bypass        = st_q.s2[3*DLY_W+9];
    assign s_start         = st_q.s2[3*DLY_W+10];
    assign s_line          = st_q.s2[3*DLY_W+11];

    // Cycles only when its jumper is fitted and the seconds jumper is not;
    // seconds otherwise, so a missing jumper falls back to the factory choice
    assign unit_cyc[CH_START] = s_jmp[0] & ~s_jmp[1];
    assign unit_cyc[CH_AUX]   = s_jmp[2] & ~s_jmp[3];
    assign unit_cyc[CH_CAP]   = s_jmp[4] & ~s_jmp[5];

    // Start channel follows the command; contact channels follow bypass closure,
    // which itself comes after the processor's own setpoint delay
    assign trig[CH_START] = s_start;
    assign trig[CH_AUX]   = s_bypass;
    assign trig[CH_CAP]   = s_bypass;

    // Three identical delay channels
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            tbdt_delay u_dly (
                .sys_clk     (sys_clk),
                .sys_rst     (sys_rst),
                .trigger     (trig[g]),
                .unit_cycles (unit_cyc[g]),
                .length      (s_len[g]),
                .sec_tick    (st_q.sec_tick),
                .cyc_tick    (st_q.cyc_tick),
                .expired     (expd[g])
            );
        end
    endgenerate

    // Next-state logic
    always_comb begin
        st_d          = st_q;
        st_d.s1       = raw;
        st_d.s2       = st_q.s1;
        st_d.sync_d1  = s_line;
        st_d.key_d1   = s_key;
        // One line cycle per rising edge of the sync input
        st_d.cyc_tick = s_line & ~st_q.sync_d1;
        // Seconds prescaler from the system clock
        if (st_q.pre == PRE_W'(SEC_CYCLES - 1)) begin
            st_d.pre      = '0;
            st_d.sec_tick = 1'b1;
        end else begin
            st_d.pre      = st_q.pre + PRE_W'(1);
            st_d.sec_tick = 1'b0;
        end
        // Trip latch: a standing fault wins over the reset key
        if (s_fault) begin
            st_d.trip = 1'b1;
        end else if (s_key & ~st_q.key_d1) begin
            st_d.trip = 1'b0;
        end
        // Relay outputs
        st_d.relay.start_now     = s_start;
        st_d.relay.start_delayed = expd[CH_START];
        st_d.relay.aux_contact   = expd[CH_AUX];
        st_d.relay.cap_contact   = expd[CH_CAP];
        st_d.relay.fault_relay   = s_fault;
        st_d.relay.fuse_relay    = s_fuse;
        st_d.relay.trip_relay    = st_d.trip;
        // Lamps
        st_d.led.start_led       = s_start;
        st_d.led.fault_led       = s_fault | st_d.trip;
        st_d.led.fuse_led        = s_fuse;
        st_d.led.cap_on_led      = expd[CH_CAP];
        st_d.led.timed_out_led   = expd[CH_AUX];
    end

    // State register; the switch sync stages come out of reset at one unit
    // so that a channel read before the first capture still has its default
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q    <= '0;
            st_q.s1 <= {{(NIN-3*DLY_W){1'b0}}, DLY_DEFAULT, DLY_DEFAULT, DLY_DEFAULT};
            st_q.s2 <= {{(NIN-3*DLY_W){1'b0}}, DLY_DEFAULT, DLY_DEFAULT, DLY_DEFAULT};
        end else begin
            st_q <= st_d;
        end
    end

    assign relay = st_q.relay;
    assign led   = st_q.led;

    // Delayed start never stands without the command
    start_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        relay.start_delayed |-> $past(s_start, 2))
        else $error("delayed start without command");

    // Capacitor lamp mirrors its contacts
    cap_lamp_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        led.cap_on_led == relay.cap_contact)
        else $error("capacitor lamp mismatch");

    // Timed-out lamp mirrors aux contacts
    aux_lamp_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        led.timed_out_led == relay.aux_contact)
        else $error("timed-out lamp mismatch");

    // Aux contacts need bypass closed
    aux_bypass_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        relay.aux_contact |-> $past(s_bypass, 2))
        else $error("aux contacts without bypass");

    // Fault relay follows fault one cycle later
    fault_relay_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        s_fault |=> relay.fault_relay && relay.trip_relay && led.fault_led)
        else $error("fault relay missed a fault");

    // Reset key press without fault releases trip
    trip_clear_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (s_key && !st_q.key_d1 && !s_fault) |=> !relay.trip_relay)
        else $error("reset key did not release trip");

    // Start lamp and immediate relay follow command
    start_lamp_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        s_start |=> led.start_led && relay.start_now)
        else $error("start lamp missed command");

    // Fuse lamp follows disconnect input
    fuse_lamp_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        s_fuse |=> led.fuse_led)
        else $error("fuse lamp missed");
endmodule : tbdt_top

// *** sim/tbdt_line_model.sv ***
// Purpose: Line-synchronous square wave standing in for the mains sense input.
// Assumes: Mains phase is unrelated to sys_clk, so edges sit off the clock edges.
// Notes:   Period is 2*HALF_NS; keep it well above the design's sync latency.
module tbdt_line_model #(
    parameter int unsigned HALF_NS = 160  // Half line period in ns
) (
    output logic line_sync  // One rising edge per line cycle
);
    timeunit 1ns;
    timeprecision 1ps;

    // Free-running wave offset from the clock grid
    initial begin
        line_sync = 1'b0;
        #3;
        forever #(HALF_NS) line_sync = ~line_sync;
    end
endmodule : tbdt_line_model

// *** sim/tb_top.sv ***
// Purpose: Self-checking bench for the terminal board delay timers.
// Assumes: Seconds ticks never fire within the run, so seconds mode never expires.
// Notes:   Cycle mode is timed against line edges counted by the bench.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import tbdt_pkg::*;

    localparam int LP = 40;  // Line period in clocks
    logic sys_clk, sys_rst, start_cmd, bypass_closed, fault_in, fuse_open, reset_key;
    logic              line_sync;       // From line model
    logic [2:0]        cyc_j, sec_j;    // Jumpers per channel
    logic [DLY_W-1:0]  sw_f [NCH];      // Switch fields per channel
    tbdt_relay_t       relay;           // Relay outputs
    tbdt_led_t         led;             // Lamps
    int                failures, n_compared, seed, i, c;
    int                corner [4] = '{0, 1, 127, 64};  // Field boundaries and top weight

    tbdt_line_model #(.HALF_NS(LP * 4)) i_line (.line_sync(line_sync));

    tbdt_top i_dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .start_cmd(start_cmd),
        .bypass_closed(bypass_closed), .fault_in(fault_in), .fuse_open(fuse_open),
        .reset_key(reset_key), .line_sync(line_sync),
        .start_delay_cycle_jumper(cyc_j[CH_START]),
        .start_delay_second_jumper(sec_j[CH_START]),
        .aux_delay_cycle_jumper(cyc_j[CH_AUX]), .aux_delay_second_jumper(sec_j[CH_AUX]),
        .capacitor_delay_cycle_jumper(cyc_j[CH_CAP]),
        .capacitor_delay_second_jumper(sec_j[CH_CAP]),
        .start_delay_switch_field(sw_f[CH_START]), .aux_delay_switch_field(sw_f[CH_AUX]),
        .capacitor_delay_switch_field(sw_f[CH_CAP]), .relay(relay), .led(led)
    );

    // Clock at 125 MHz
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // Compare one result and report a mismatch
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // Verdict and end of run
    task automatic wrap_up();
        if (failures == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : wrap_up

    // Delayed output of a channel
    function automatic logic ch_out(input int ch);
        return (ch == CH_START) ? relay.start_delayed :
               (ch == CH_AUX) ? relay.aux_contact : relay.cap_contact;
    endfunction : ch_out

    // Lamp that belongs to a channel
    function automatic logic ch_lamp(input int ch);
        return (ch == CH_START) ? led.start_led :
               (ch == CH_AUX) ? led.timed_out_led : led.cap_on_led;
    endfunction : ch_lamp

    // Start drives the first channel, bypass the other two
    task automatic set_trig(input int ch, input logic v);
        if (ch == CH_START) begin
            start_cmd = v;
        end else begin
            bypass_closed = v;
        end
    endtask : set_trig

    task automatic wait_clk(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : wait_clk

    // One cycle-mode delay of n units, timed in line edges
    task automatic run_cyc(input int ch, input int n);
        int   cnt;
        int   t;
        logic prev;
        cyc_j[ch] = 1'b1;
        sec_j[ch] = 1'b0;
        sw_f[ch]  = n[6:0];
        // Start well clear of a line edge so it is not counted twice; the wait is
        // bounded so a dead line model ends the run instead of hanging it
        prev = line_sync;
        for (t = 0; t < LP * 2 && !(line_sync && !prev); t++) begin
            prev = line_sync;
            @(negedge sys_clk);
        end
        if (t == LP * 2) begin
            chk("line wait", 8'h01, 8'h00);
            wrap_up();
        end
        wait_clk(5);
        set_trig(ch, 1'b1);
        prev = line_sync;
        cnt  = 0;
        for (t = 0; t < LP * 130 && ch_out(ch) !== 1'b1; t++) begin
            @(negedge sys_clk);
            if (line_sync && !prev) begin
                cnt++;
            end
            prev = line_sync;
        end
        if (t == LP * 130) begin
            chk("delay wait", 8'h01, 8'h00);
            wrap_up();
        end
        chk("delay units", n[7:0], cnt[7:0]);
        wait_clk(2);
        chk("channel lamp", 8'h01, {7'h00, ch_lamp(ch)});
        if (ch == CH_START) begin
            chk("start_now", 8'h01, {7'h00, relay.start_now});
        end
        set_trig(ch, 1'b0);
        wait_clk(6);
        chk("output cleared", 8'h00, {7'h00, ch_out(ch)});
        chk("lamp cleared", 8'h00, {7'h00, ch_lamp(ch)});
    endtask : run_cyc

    task automatic pulse_key();
        reset_key = 1'b1;
        wait_clk(3);
        reset_key = 1'b0;
        wait_clk(5);
    endtask : pulse_key

    // Main sequence
    initial begin
        {start_cmd, bypass_closed, fault_in, fuse_open, reset_key} = 5'h00;
        cyc_j = 3'b000;
        sec_j = 3'b111;
        sw_f  = '{DLY_DEFAULT, DLY_DEFAULT, DLY_DEFAULT};
        failures = 0;
        n_compared = 0;
        seed = 27832;
        sys_rst = 1'b1;
        wait_clk(12);
        sys_rst = 1'b0;
        wait_clk(2);
        chk("relay after reset", 8'h00, {1'b0, relay});
        chk("led after reset", 8'h00, {3'h0, led});
        // Seconds and ambiguous jumper settings never expire within the run
        for (i = 0; i < 3; i++) begin
            cyc_j = (i == 1) ? 3'b111 : 3'b000;
            sec_j = (i == 2) ? 3'b000 : 3'b111;
            sw_f  = '{DLY_DEFAULT, DLY_DEFAULT, DLY_DEFAULT};
            start_cmd = 1'b1;
            bypass_closed = 1'b1;
            wait_clk(LP * 5);
            chk("seconds start", 8'h00, {7'h00, relay.start_delayed});
            chk("seconds aux", 8'h00, {7'h00, relay.aux_contact});
            chk("seconds cap", 8'h00, {7'h00, relay.cap_contact});
            start_cmd = 1'b0;
            bypass_closed = 1'b0;
            wait_clk(6);
        end
        // Field boundaries, then random lengths
        for (c = 0; c < NCH; c++) begin
            for (i = 0; i < 4; i++) begin
                run_cyc(c, corner[i]);
            end
        end
        for (i = 0; i < 6; i++) begin
            run_cyc(i % NCH, $random(seed) & 127);
        end
        // Fault latch and reset key
        fault_in = 1'b1;
        wait_clk(5);
        chk("fault relay", 8'h01, {7'h00, relay.fault_relay});
        chk("fault lamp", 8'h01, {7'h00, led.fault_led});
        pulse_key();
        chk("trip held", 8'h01, {7'h00, relay.trip_relay});
        fault_in = 1'b0;
        wait_clk(5);
        chk("fault relay off", 8'h00, {7'h00, relay.fault_relay});
        chk("trip latched", 8'h01, {7'h00, relay.trip_relay});
        pulse_key();
        chk("trip released", 8'h00, {7'h00, relay.trip_relay});
        chk("fault lamp off", 8'h00, {7'h00, led.fault_led});
        // Fuse or disconnect
        fuse_open = 1'b1;
        wait_clk(5);
        chk("fuse lamp", 8'h01, {7'h00, led.fuse_led});
        chk("fuse relay", 8'h01, {7'h00, relay.fuse_relay});
        fuse_open = 1'b0;
        wait_clk(5);
        chk("fuse lamp off", 8'h00, {7'h00, led.fuse_led});
        chk("fuse relay off", 8'h00, {7'h00, relay.fuse_relay});
        wrap_up();
    end
endmodule : tb_top
